/* File: sps_far_end.sv */
// Far-end model: enable contacts and serial bus command lines.
`timescale 1ns/100ps
module sps_far_end (
   input wire logic core_clk,
   output logic [1:0] contact,
   output logic [3:0] bus_cmd
);
   initial begin
      contact = 2'h0;
      bus_cmd = 4'h0;
   end
   // Held commands stay up long past detection, so a level-acting receiver would fire on every cycle of the hold.
   task automatic send(input int idx, input bit held);
      @(posedge core_clk) bus_cmd[idx] <= 1'b1;
      repeat (held ? 40 : 1) @(posedge core_clk);
      bus_cmd[idx] <= 1'b0;
   endtask
   task automatic set_contact(input int idx, input bit closed);
      @(posedge core_clk) contact[idx] <= closed;
   endtask
endmodule

/* File: sps_mode_ctrl.sv */
// Remote speed setpoint and cascade mode control with APB register access.
`timescale 1ns/100ps
module sps_mode_ctrl #(
   parameter int unsigned RAMP_CYC = sps_pkg::RAMP_STEP_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rss_contact,
   input wire logic casc_contact,
   input wire logic bus_rss_en,
   input wire logic bus_rss_dis,
   input wire logic bus_casc_en,
   input wire logic bus_casc_dis,
   input wire logic man_raise,
   input wire logic man_lower,
   input wire logic dyn_contact,
   input wire logic trip_clear,
   input wire logic ctrl_stop,
   input wire logic shutdown,
   input wire logic stage_trip,
   input wire logic near_ctrl_line,
   input wire logic decouple_en,
   input wire logic spd_pid_in_ctrl,
   input wire logic casc_pv_fail,
   input wire logic rem_casc_sp_act,
   input wire logic [15:0] speed,
   input wire logic [15:0] rem_ua,
   input wire logic [15:0] casc_pv,
   input wire logic [15:0] casc_sp,
   output logic [2:0] rss_state,
   output logic [2:0] casc_state,
   output logic rss_enabled,
   output logic casc_enabled,
   output logic rem_alarm,
   output logic dyn_set2,
   output logic [15:0] spd_ref
);
   logic [sps_pkg::NPIN-1:0] pin_raw;
   logic [sps_pkg::NPIN-1:0] lvl;
   logic [sps_pkg::NPIN-1:0] rise;
   logic [sps_pkg::NPIN-1:0] fall;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] cfg_r;
   logic [31:0] gov_r;
   logic [31:0] remmap_r;
   logic [31:0] rate_r;
   logic [15:0] entry_r;
   logic entry_act_r;
   logic rss_en_r;
   logic casc_en_r;
   logic [2:0] rss_st_r;
   logic [2:0] casc_st_r;
   logic alarm_r;
   logic set2_r;
   logic [15:0] ref_r;
   logic [19:0] tick_cnt_r;
   logic [15:0] rem_tgt;

   // The fifteen pins in pin_raw come from outside the clock domain, so each passes a synchroniser.
   assign pin_raw = {decouple_en, near_ctrl_line, stage_trip, shutdown, ctrl_stop, trip_clear, dyn_contact,
                     man_lower, man_raise, bus_casc_dis, bus_casc_en, bus_rss_dis, bus_rss_en, casc_contact,
                     rss_contact};

   for (genvar i = 0; i < sps_pkg::NPIN; i++) begin : g_pin
      sps_sync_edge u_sync (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .pin_in(pin_raw[i]),
         .lvl(lvl[i]),
         .rise(rise[i]),
         .fall(fall[i])
      );
   end

   // APB slave: one wait state, writes land on the completing edge.
   logic apb_acc;
   logic wr_fire;
   logic addr_ok;
   logic [15:0] min_gov;
   logic [15:0] max_gov;
   assign apb_acc = psel & penable & ~pready_r;
   assign wr_fire = psel & penable & pready_r & pwrite;
   assign addr_ok = (paddr == sps_pkg::ADDR_CFG) | (paddr == sps_pkg::ADDR_CMD) | (paddr == sps_pkg::ADDR_GOV) |
                    (paddr == sps_pkg::ADDR_REMMAP) | (paddr == sps_pkg::ADDR_RATE) |
                    (paddr == sps_pkg::ADDR_STATUS) | (paddr == sps_pkg::ADDR_SPDREF) |
                    (paddr == sps_pkg::ADDR_ENTRY);
   assign min_gov = gov_r[15:0];
   assign max_gov = gov_r[31:16];

   logic cmd_wr;
   logic cmd_rss_en;
   logic cmd_rss_dis;
   logic cmd_casc_en;
   logic cmd_casc_dis;
   assign cmd_wr = wr_fire & (paddr == sps_pkg::ADDR_CMD);
   assign cmd_rss_en = cmd_wr & pwdata[sps_pkg::CMD_RSS_EN];
   assign cmd_rss_dis = cmd_wr & pwdata[sps_pkg::CMD_RSS_DIS];
   assign cmd_casc_en = cmd_wr & pwdata[sps_pkg::CMD_CASC_EN];
   assign cmd_casc_dis = cmd_wr & pwdata[sps_pkg::CMD_CASC_DIS];

   logic [31:0] status_w;
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[sps_pkg::ST_RSS_LSB +: 3] = rss_st_r;
      status_w[sps_pkg::ST_CASC_LSB +: 3] = casc_st_r;
      status_w[sps_pkg::ST_RSS_EN] = rss_en_r;
      status_w[sps_pkg::ST_CASC_EN] = casc_en_r;
      status_w[sps_pkg::ST_ALARM] = alarm_r;
      status_w[sps_pkg::ST_SET2] = set2_r;
      status_w[sps_pkg::ST_ENTRY] = entry_act_r;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= apb_acc;
         pslverr_r <= apb_acc & ~addr_ok;
         if (apb_acc && !pwrite) begin
            unique case (paddr)
               sps_pkg::ADDR_CFG: prdata_r <= cfg_r;
               sps_pkg::ADDR_GOV: prdata_r <= gov_r;
               sps_pkg::ADDR_REMMAP: prdata_r <= remmap_r;
               sps_pkg::ADDR_RATE: prdata_r <= rate_r;
               sps_pkg::ADDR_STATUS: prdata_r <= status_w;
               sps_pkg::ADDR_SPDREF: prdata_r <= {rem_tgt, ref_r};
               sps_pkg::ADDR_ENTRY: prdata_r <= {16'h0000, entry_r};
               default: prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= sps_pkg::CFG_RST;
         gov_r <= sps_pkg::GOV_RST;
         remmap_r <= sps_pkg::REMMAP_RST;
         rate_r <= sps_pkg::RATE_RST;
      end else if (wr_fire) begin
         if (paddr == sps_pkg::ADDR_CFG) begin
            cfg_r <= pwdata;
         end
         if (paddr == sps_pkg::ADDR_GOV) begin
            gov_r <= pwdata;
         end
         if (paddr == sps_pkg::ADDR_REMMAP) begin
            remmap_r <= pwdata;
         end
         if (paddr == sps_pkg::ADDR_RATE) begin
            rate_r <= pwdata;
         end
      end
   end

   // Remote analog input: fault band, linear map and clamp to governor limits.
   logic rem_fault;
   logic signed [34:0] rem_off;
   logic signed [34:0] rem_sum;
   assign rem_fault = (rem_ua < sps_pkg::REM_FAULT_LO_UA) | (rem_ua > sps_pkg::REM_FAULT_HI_UA);
   assign rem_off = $signed({19'h00000, rem_ua}) - $signed({19'h00000, sps_pkg::REM_LOW_UA});
   assign rem_sum = ((rem_off * $signed({19'h00000, remmap_r[31:16]})) >>> sps_pkg::REM_GAIN_SHIFT) +
                    $signed({19'h00000, remmap_r[15:0]});
   always_comb begin
      if (rem_sum < $signed({19'h00000, min_gov})) begin
         rem_tgt = min_gov;
      end else if (rem_sum > $signed({19'h00000, max_gov})) begin
         rem_tgt = max_gov;
      end else begin
         rem_tgt = rem_sum[15:0];
      end
   end

   // Inhibits and command events from terminal, contacts and serial bus.
   logic rss_inh;
   logic casc_inh;
   logic rss_on_req;
   logic rss_off_req;
   logic casc_on_req;
   logic casc_off_req;
   logic rss_on_ok;
   logic casc_on_ok;
   assign rss_inh = rem_fault | lvl[sps_pkg::P_STOP] | lvl[sps_pkg::P_SHUTDOWN] | ~cfg_r[sps_pkg::CFG_RSS];
   assign casc_inh = casc_pv_fail | lvl[sps_pkg::P_STOP] | lvl[sps_pkg::P_SHUTDOWN] |
                     ~cfg_r[sps_pkg::CFG_CASC] | lvl[sps_pkg::P_STAGE_TRIP];
   // Contacts enable only on a closing edge, so a contact already closed at trip clear needs reclosing.
   assign rss_on_req = cmd_rss_en | rise[sps_pkg::P_BUS_RSS_EN] |
                       (cfg_r[sps_pkg::CFG_RSS_CT] & rise[sps_pkg::P_RSS_CT]);
   assign rss_off_req = cmd_rss_dis | rise[sps_pkg::P_BUS_RSS_DIS] | rise[sps_pkg::P_TRIP_CLR] |
                        (cfg_r[sps_pkg::CFG_RSS_CT] & fall[sps_pkg::P_RSS_CT]);
   assign casc_on_req = cmd_casc_en | rise[sps_pkg::P_BUS_CASC_EN] |
                        (cfg_r[sps_pkg::CFG_CASC_CT] & rise[sps_pkg::P_CASC_CT]);
   assign casc_off_req = cmd_casc_dis | rise[sps_pkg::P_BUS_CASC_DIS] | rise[sps_pkg::P_TRIP_CLR] |
                         (cfg_r[sps_pkg::CFG_CASC_CT] & fall[sps_pkg::P_CASC_CT]);
   // A disable in the same cycle wins; a remote enable wins over a simultaneous cascade enable.
   assign rss_on_ok = rss_on_req & ~rss_off_req & ~rss_inh;
   assign casc_on_ok = casc_on_req & ~casc_off_req & ~casc_inh & ~rss_on_ok;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rss_en_r <= 1'b0;
      end else if (rss_inh || rss_off_req || casc_on_ok) begin
         rss_en_r <= 1'b0;
      end else if (rss_on_ok) begin
         rss_en_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         casc_en_r <= 1'b0;
      end else if (casc_inh || casc_off_req || rss_on_ok) begin
         casc_en_r <= 1'b0;
      end else if (casc_on_ok) begin
         casc_en_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_r <= 1'b0;
      end else begin
         alarm_r <= rem_fault;
      end
   end

   // Control authority of each function.
   logic [15:0] casc_min;
   logic rss_drv;
   logic casc_take;
   logic casc_ctrl;
   assign casc_min = cfg_r[sps_pkg::CFG_CMINSPD] ? rate_r[31:16] : min_gov;
   assign rss_drv = rss_en_r & (speed >= min_gov);
   assign casc_take = casc_en_r & (speed > casc_min);
   assign casc_ctrl = casc_take & spd_pid_in_ctrl;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rss_st_r <= sps_pkg::RSS_DIS;
      end else if (rss_inh) begin
         rss_st_r <= sps_pkg::RSS_INH;
      end else if (rss_drv && spd_pid_in_ctrl) begin
         rss_st_r <= sps_pkg::RSS_INCTL;
      end else if (rss_drv) begin
         rss_st_r <= sps_pkg::RSS_ACT;
      end else if (rss_en_r) begin
         rss_st_r <= sps_pkg::RSS_EN;
      end else begin
         rss_st_r <= sps_pkg::RSS_DIS;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         casc_st_r <= sps_pkg::CASC_DIS;
      end else if (casc_inh) begin
         casc_st_r <= sps_pkg::CASC_INH;
      end else if (casc_ctrl) begin
         casc_st_r <= rem_casc_sp_act ? sps_pkg::CASC_INCTL_REM : sps_pkg::CASC_INCTL;
      end else if (casc_take) begin
         casc_st_r <= rem_casc_sp_act ? sps_pkg::CASC_ACT_REM : sps_pkg::CASC_ACT;
      end else if (casc_en_r) begin
         casc_st_r <= sps_pkg::CASC_EN;
      end else begin
         casc_st_r <= sps_pkg::CASC_DIS;
      end
   end

   // Entered setpoint is refused while remote setpoint is enabled or out of governor range.
   logic entry_wr;
   assign entry_wr = wr_fire & (paddr == sps_pkg::ADDR_ENTRY) & ~rss_en_r & (pwdata[15:0] >= min_gov) &
                     (pwdata[15:0] <= max_gov);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         entry_r <= sps_pkg::REF_RST;
         entry_act_r <= 1'b0;
      end else if (entry_wr) begin
         entry_r <= pwdata[15:0];
         entry_act_r <= 1'b1;
      end else if (rss_en_r || casc_ctrl || lvl[sps_pkg::P_RAISE] || lvl[sps_pkg::P_LOWER] || ref_r == entry_r) begin
         entry_act_r <= 1'b0;
      end
   end

   // Reference ramp: one step of the configured rate per ramp period.
   logic tick;
   assign tick = (tick_cnt_r == 20'(RAMP_CYC - 1));
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= 20'h00000;
      end else if (tick) begin
         tick_cnt_r <= 20'h00000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 20'h00001;
      end
   end

   logic near;
   logic want_up;
   logic want_dn;
   logic [15:0] up_lim;
   logic [15:0] dn_lim;
   logic [16:0] ref_up;
   logic [16:0] ref_dn;
   assign near = lvl[sps_pkg::P_NEAR_LINE];
   always_comb begin
      up_lim = max_gov;
      dn_lim = min_gov;
      want_up = 1'b0;
      want_dn = 1'b0;
      if (rss_en_r) begin
         // Other sources are ignored; the remote value drives only at or above minimum governor.
         up_lim = rem_tgt;
         dn_lim = rem_tgt;
         want_up = rss_drv & (ref_r < rem_tgt);
         want_dn = rss_drv & (ref_r > rem_tgt) & ~near;
      end else if (casc_ctrl) begin
         want_up = casc_pv < casc_sp;
         want_dn = (casc_pv > casc_sp) & ~near;
      end else if (entry_act_r) begin
         up_lim = entry_r;
         dn_lim = entry_r;
         want_up = ref_r < entry_r;
         want_dn = (ref_r > entry_r) & ~near;
      end else begin
         // Discrete lowers stay allowed near the control line for operator flexibility.
         want_up = lvl[sps_pkg::P_RAISE];
         want_dn = lvl[sps_pkg::P_LOWER];
      end
   end

   assign ref_up = {1'b0, ref_r} + {1'b0, rate_r[15:0]};
   assign ref_dn = {1'b0, ref_r} - {1'b0, rate_r[15:0]};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_r <= sps_pkg::REF_RST;
      end else if (tick && want_up) begin
         ref_r <= (ref_up > {1'b0, up_lim}) ? up_lim : ref_up[15:0];
      end else if (tick && want_dn) begin
         ref_r <= (ref_dn[16] || ref_dn[15:0] < dn_lim) ? dn_lim : ref_dn[15:0];
      end
   end

   // Tuning set selection.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         set2_r <= 1'b0;
      end else begin
         unique case (cfg_r[sps_pkg::CFG_DYN_LSB +: 2])
            sps_pkg::DYN_MINGOV: set2_r <= speed > min_gov;
            sps_pkg::DYN_CONTACT: set2_r <= lvl[sps_pkg::P_DYN_CT];
            sps_pkg::DYN_DECOUPLE: set2_r <= lvl[sps_pkg::P_DECOUPLE];
            sps_pkg::DYN_NONE: set2_r <= 1'b0;
         endcase
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign rss_state = rss_st_r;
   assign casc_state = casc_st_r;
   assign rss_enabled = rss_en_r;
   assign casc_enabled = casc_en_r;
   assign rem_alarm = alarm_r;
   assign dyn_set2 = set2_r;
   assign spd_ref = ref_r;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence clr_closed_s;
      rise[sps_pkg::P_TRIP_CLR] && lvl[sps_pkg::P_RSS_CT];
   endsequence
   sequence held_closed_s;
      (lvl[sps_pkg::P_RSS_CT] && !cmd_rss_en && !rise[sps_pkg::P_BUS_RSS_EN])[*3];
   endsequence

   never_both_a: assert property (!(rss_en_r && casc_en_r))
      else $error("Remote setpoint and cascade enabled together.");
   rss_kills_casc_a: assert property (rss_on_ok |=> !casc_en_r && rss_en_r)
      else $error("Remote enable did not disable cascade.");
   casc_kills_rss_a: assert property (casc_on_ok |=> casc_en_r && !rss_en_r)
      else $error("Cascade enable did not disable remote setpoint.");
   fault_disables_a: assert property (rem_fault |=> !rss_en_r && alarm_r && rss_st_r == sps_pkg::RSS_INH)
      else $error("Remote input fault not handled.");
   rearm_closed_a: assert property (clr_closed_s ##1 held_closed_s |-> !rss_en_r)
      else $error("Remote enabled by contact held closed through trip clear.");
   bus_held_a: assert property (lvl[sps_pkg::P_BUS_RSS_EN] && $past(lvl[sps_pkg::P_BUS_RSS_EN]) && !cmd_rss_en
                                && !rise[sps_pkg::P_RSS_CT] |-> !rss_on_req)
      else $error("Held bus command treated as new edge.");
   target_clamp_a: assert property (min_gov <= max_gov |-> rem_tgt >= min_gov && rem_tgt <= max_gov)
      else $error("Remote target outside governor limits.");
   no_rss_lower_a: assert property (rss_en_r && near && tick |=> ref_r >= $past(ref_r))
      else $error("Remote setpoint lowered near control line.");
   no_casc_lower_a: assert property (!rss_en_r && casc_ctrl && near && tick |=> ref_r >= $past(ref_r))
      else $error("Cascade lowered reference near control line.");
   stage_trip_a: assert property (lvl[sps_pkg::P_STAGE_TRIP] |=> casc_st_r == sps_pkg::CASC_INH && !casc_en_r)
      else $error("Stage trip did not inhibit cascade.");
   mingov_set2_a: assert property (cfg_r[sps_pkg::CFG_DYN_LSB +: 2] == sps_pkg::DYN_MINGOV && speed > min_gov
                                   |=> set2_r)
      else $error("Tuning set two not selected above minimum governor.");
   rss_inctl_a: assert property (!rss_inh && rss_drv && spd_pid_in_ctrl |=> rss_st_r == sps_pkg::RSS_INCTL)
      else $error("Remote in-control state not reported.");
   casc_ctrl_gate_a: assert property (casc_st_r == sps_pkg::CASC_INCTL |-> $past(spd_pid_in_ctrl)
                                      && $past(casc_en_r))
      else $error("Cascade in control without regulator or enable.");
endmodule

/* File: sps_pkg.sv */
// Constants shared by the setpoint source mode control block.
// Behaviour
// - Last command from any source sets remote enable.
// - Remote contact open disables, closed enables.
// - Contact closed at trip clear needs reclosing.
// - Serial bus commands act on rising edge only.
// - Remote setpoint ramps reference at remote rate.
// - Remote input mapped, clamped to governor limits.
// - Out-of-band input alarms, disables, inhibits remote.
// - Remote enable immediately disables active cascade.
// - Cascade enable disables remote; never both.
// - Remote enabled ignores raise, lower, entered setpoint.
// - Remote decreases blocked near compressor control line.
// - Remote status reports one of five states.
// - Remote inhibited on fault, stop, shutdown, unconfigured.
// - Minimum governor switch selects tuning set two.
// - Contact or decoupling switch selects tuning set two.
// - Cascade moves reference until process matches setpoint.
// - Cascade enable follows last command; contact edges.
// - Cascade contact closed at trip clear needs reclosing.
// - Cascade controls only with regulator and speed.
// - Stage trip to full recycle inhibits cascade.
// - Cascade lower commands blocked near control line.
// - Cascade status reports one of seven states.
package sps_pkg;

   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned RAMP_STEP_NS = 1000000;
   localparam int unsigned RAMP_STEP_CYC = RAMP_STEP_NS / CLK_PERIOD_NS;

   localparam logic [15:0] REM_LOW_UA = 16'h0fa0;
   localparam logic [15:0] REM_FAULT_LO_UA = 16'h07d0;
   localparam logic [15:0] REM_FAULT_HI_UA = 16'h55f0;
   localparam int unsigned REM_GAIN_SHIFT = 12;

   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_GOV = 8'h08;
   localparam logic [7:0] ADDR_REMMAP = 8'h0c;
   localparam logic [7:0] ADDR_RATE = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_SPDREF = 8'h18;
   localparam logic [7:0] ADDR_ENTRY = 8'h1c;

   localparam int unsigned CFG_RSS = 0;
   localparam int unsigned CFG_CASC = 1;
   localparam int unsigned CFG_CMINSPD = 2;
   localparam int unsigned CFG_DYN_LSB = 3;
   localparam int unsigned CFG_RSS_CT = 5;
   localparam int unsigned CFG_CASC_CT = 6;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;

   localparam int unsigned CMD_RSS_EN = 0;
   localparam int unsigned CMD_RSS_DIS = 1;
   localparam int unsigned CMD_CASC_EN = 2;
   localparam int unsigned CMD_CASC_DIS = 3;

   localparam logic [31:0] GOV_RST = 32'h0e10_03e8;
   localparam logic [31:0] REMMAP_RST = 32'h0299_03e8;
   localparam logic [31:0] RATE_RST = 32'h0000_0001;
   localparam logic [15:0] REF_RST = 16'h03e8;

   localparam int unsigned ST_RSS_LSB = 0;
   localparam int unsigned ST_CASC_LSB = 4;
   localparam int unsigned ST_RSS_EN = 8;
   localparam int unsigned ST_CASC_EN = 9;
   localparam int unsigned ST_ALARM = 10;
   localparam int unsigned ST_SET2 = 11;
   localparam int unsigned ST_ENTRY = 12;

   localparam logic [2:0] RSS_DIS = 3'h0;
   localparam logic [2:0] RSS_EN = 3'h1;
   localparam logic [2:0] RSS_ACT = 3'h2;
   localparam logic [2:0] RSS_INCTL = 3'h3;
   localparam logic [2:0] RSS_INH = 3'h4;

   localparam logic [2:0] CASC_DIS = 3'h0;
   localparam logic [2:0] CASC_EN = 3'h1;
   localparam logic [2:0] CASC_ACT = 3'h2;
   localparam logic [2:0] CASC_INCTL = 3'h3;
   localparam logic [2:0] CASC_ACT_REM = 3'h4;
   localparam logic [2:0] CASC_INCTL_REM = 3'h5;
   localparam logic [2:0] CASC_INH = 3'h6;

   localparam logic [1:0] DYN_NONE = 2'h0;
   localparam logic [1:0] DYN_MINGOV = 2'h1;
   localparam logic [1:0] DYN_CONTACT = 2'h2;
   localparam logic [1:0] DYN_DECOUPLE = 2'h3;

   localparam int unsigned NPIN = 15;
   localparam int unsigned P_RSS_CT = 0;
   localparam int unsigned P_CASC_CT = 1;
   localparam int unsigned P_BUS_RSS_EN = 2;
   localparam int unsigned P_BUS_RSS_DIS = 3;
   localparam int unsigned P_BUS_CASC_EN = 4;
   localparam int unsigned P_BUS_CASC_DIS = 5;
   localparam int unsigned P_RAISE = 6;
   localparam int unsigned P_LOWER = 7;
   localparam int unsigned P_DYN_CT = 8;
   localparam int unsigned P_TRIP_CLR = 9;
   localparam int unsigned P_STOP = 10;
   localparam int unsigned P_SHUTDOWN = 11;
   localparam int unsigned P_STAGE_TRIP = 12;
   localparam int unsigned P_NEAR_LINE = 13;
   localparam int unsigned P_DECOUPLE = 14;

endpackage

/* File: sps_sync_edge.sv */
// Two-flop pin synchroniser with rising and falling edge detection.
`timescale 1ns/100ps
module sps_sync_edge (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic lvl,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign lvl = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule

/* File: test_sps_mode_ctrl.sv */
// Self-checking bench for the setpoint source mode control block.
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
$display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module test_sps_mode_ctrl;
   logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, man_raise = 1'b0, man_lower = 1'b0, dyn_contact = 1'b0, trip_clear = 1'b0;
   logic ctrl_stop = 1'b0, shutdown = 1'b0, stage_trip = 1'b0, near_ctrl_line = 1'b0, decouple_en = 1'b0;
   logic spd_pid_in_ctrl = 1'b0, casc_pv_fail = 1'b0, rem_casc_sp_act = 1'b0;
   logic [15:0] speed = 16'h0000, rem_ua = 16'h0fa0, casc_pv = 16'h0000, casc_sp = 16'h0000;
   logic [2:0] rss_state, casc_state;
   logic rss_enabled, casc_enabled, rem_alarm, dyn_set2;
   logic [15:0] spd_ref;
   wire logic rss_contact, casc_contact, bus_rss_en, bus_rss_dis, bus_casc_en, bus_casc_dis;
   logic [32:0] exp_q[$], msk_q[$], m, x;
   wire logic [11:0] pin_st = {dyn_set2, rem_alarm, casc_enabled, rss_enabled, 1'b0, casc_state, 1'b0, rss_state};
   int checked = 0, error_cnt = 0, cyc = 0, seed = 32;
   localparam logic [32:0] SM = 33'h1_0000_1fff;
   always #4 core_clk = ~core_clk;
   sps_mode_ctrl #(.RAMP_CYC(8)) sps_mode_ctrl_i (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rss_contact, .casc_contact, .bus_rss_en, .bus_rss_dis,
      .bus_casc_en, .bus_casc_dis, .man_raise, .man_lower, .dyn_contact, .trip_clear, .ctrl_stop,
      .shutdown, .stage_trip, .near_ctrl_line, .decouple_en, .spd_pid_in_ctrl, .casc_pv_fail,
      .rem_casc_sp_act, .speed, .rem_ua, .casc_pv, .casc_sp, .rss_state, .casc_state, .rss_enabled,
      .casc_enabled, .rem_alarm, .dyn_set2, .spd_ref);
   sps_far_end sps_far_end_i (.core_clk, .contact({casc_contact, rss_contact}),
      .bus_cmd({bus_casc_dis, bus_casc_en, bus_rss_dis, bus_rss_en}));
   task automatic tally_and_finish;
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Request and data are held until pready is seen high at a rising edge.
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk) penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] k);
      exp_q.push_back(e);
      msk_q.push_back(k);
      apb(a, 1'b0, 32'h0);
   endtask
   task automatic settle;
      repeat (8) @(posedge core_clk);
   endtask
   function automatic logic [32:0] st(input logic [2:0] r, input logic [2:0] c, input logic [3:0] f);
      return {21'h0, f, 1'b0, c, 1'b0, r};
   endfunction
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
         m = msk_q.pop_front();
         x = exp_q.pop_front();
         `CHK({pslverr, prdata} & m, x)
         if (paddr == sps_pkg::ADDR_STATUS) `CHK(pin_st & m[11:0], x[11:0])
         if (paddr == sps_pkg::ADDR_SPDREF) `CHK(spd_ref, x[15:0])
      end
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      speed = 16'($random(seed)) & 16'h01ff;
      man_raise = 1'($random(seed));
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_INH, sps_pkg::CASC_INH, 4'h0), SM);
      rd(8'h20, 33'h1_0000_0000, {33{1'b1}});
      rd(sps_pkg::ADDR_GOV, {1'b0, sps_pkg::GOV_RST}, {33{1'b1}});
      apb(sps_pkg::ADDR_CFG, 1'b1, 32'h0000_0063);
      sps_far_end_i.send(0, 1'b1);
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_EN, sps_pkg::CASC_DIS, 4'h1), SM);
      sps_far_end_i.send(1, 1'b0);
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_DIS, sps_pkg::CASC_DIS, 4'h0), SM);
      apb(sps_pkg::ADDR_CMD, 1'b1, 32'h0000_0004);
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_DIS, sps_pkg::CASC_EN, 4'h2), SM);
      sps_far_end_i.set_contact(0, 1'b1);
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_EN, sps_pkg::CASC_DIS, 4'h1), SM);
      sps_far_end_i.send(2, 1'b0);
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_DIS, sps_pkg::CASC_EN, 4'h2), SM);
      stage_trip <= 1'b1;
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_DIS, sps_pkg::CASC_INH, 4'h0), SM);
      stage_trip <= 1'b0;
      trip_clear <= 1'b1;
      settle();
      trip_clear <= 1'b0;
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_DIS, sps_pkg::CASC_DIS, 4'h0), SM);
      sps_far_end_i.set_contact(0, 1'b0);
      settle();
      sps_far_end_i.set_contact(0, 1'b1);
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_EN, sps_pkg::CASC_DIS, 4'h1), SM);
      apb(sps_pkg::ADDR_RATE, 1'b1, 32'h0000_ffff);
      speed <= 16'h0800;
      spd_pid_in_ctrl <= 1'b1;
      rem_ua <= 16'h1f40;
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_INCTL, sps_pkg::CASC_DIS, 4'h1), SM);
      rd(sps_pkg::ADDR_SPDREF, 33'h0_0671_0671, {33{1'b1}});
      near_ctrl_line <= 1'b1;
      settle();
      rem_ua <= 16'h0fa0;
      settle();
      rd(sps_pkg::ADDR_SPDREF, 33'h0_03e8_0671, {33{1'b1}});
      rem_ua <= 16'h07cf;
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_INH, sps_pkg::CASC_DIS, 4'h4), SM);
      rem_ua <= 16'h0fa0 + (16'($random(seed)) & 16'h3fff);
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_DIS, sps_pkg::CASC_DIS, 4'h0), SM);
      shutdown <= 1'b1;
      dyn_contact <= 1'b1;
      apb(sps_pkg::ADDR_CFG, 1'b1, 32'h0000_0073);
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_INH, sps_pkg::CASC_INH, 4'h8), 33'h1_0000_0877);
      apb(sps_pkg::ADDR_CFG, 1'b1, 32'h0000_006b);
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_INH, sps_pkg::CASC_INH, 4'h8), 33'h1_0000_0877);
      decouple_en <= 1'b1;
      apb(sps_pkg::ADDR_CFG, 1'b1, 32'h0000_007b);
      settle();
      rd(sps_pkg::ADDR_STATUS, st(sps_pkg::RSS_INH, sps_pkg::CASC_INH, 4'h8), 33'h1_0000_0877);
      tally_and_finish();
   end
endmodule
